/* File: pkg/ccr_pkg.sv */
package ccr_pkg;

  // Command codes of the four configuration registers
  localparam int NUM_REGS = 4;
  localparam int IDX_W = 2;
  localparam logic [7:0] ADDR_LOOP_FREQ = 8'hd3;
  localparam logic [7:0] ADDR_OFFSET = 8'hd4;
  localparam logic [7:0] ADDR_BIAS = 8'hd6;
  localparam logic [7:0] ADDR_PG_TRK = 8'hd7;
  localparam int IDX_LOOP_FREQ = 0;
  localparam int IDX_OFFSET = 1;
  localparam int IDX_BIAS = 2;
  localparam int IDX_PG_TRK = 3;
  localparam logic [7:0] REG_ADDR [NUM_REGS] = '{ADDR_LOOP_FREQ, ADDR_OFFSET, ADDR_BIAS,
                                                 ADDR_PG_TRK};

  // Writable bits; all others are reserved and read as zero
  localparam logic [7:0] MASK_LOOP_FREQ = 8'hb7;
  localparam logic [7:0] MASK_OFFSET = 8'he0;
  localparam logic [7:0] MASK_BIAS = 8'h07;
  localparam logic [7:0] MASK_PG_TRK = 8'hdf;
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{MASK_LOOP_FREQ, MASK_OFFSET, MASK_BIAS,
                                                 MASK_PG_TRK};

  // Field positions
  localparam int RIE_BIT = 7;
  localparam int RRS_LSB = 4;
  localparam int RRS_W = 2;
  localparam int FSW_LSB = 0;
  localparam int FSW_W = 3;
  localparam int OSS_BIT = 7;
  localparam int TRIM_LSB = 5;
  localparam int TRIM_W = 2;
  localparam int BLT_LSB = 0;
  localparam int BLT_W = 3;
  localparam int BLT_RANGE_BIT = 2;
  localparam int PGW_BIT = 7;
  localparam int SPARE_BIT = 6;
  localparam int BYP_BIT = 4;
  localparam int TGT_LSB = 0;
  localparam int TGT_W = 4;

  // Reset values; strapped and nonvolatile bits start at zero and load after reset
  localparam logic [FSW_W-1:0] FSW_RST = 3'h3;
  localparam logic [TGT_W-1:0] TGT_RST = 4'hf;
  localparam logic [7:0] RST_LOOP_FREQ = 8'h03;
  localparam logic [7:0] RST_OFFSET = 8'h80;
  localparam logic [7:0] RST_BIAS = 8'h00;
  localparam logic [7:0] RST_PG_TRK = 8'h8f;
  localparam logic [7:0] REG_RST [NUM_REGS] = '{RST_LOOP_FREQ, RST_OFFSET, RST_BIAS,
                                                RST_PG_TRK};

  // Decode tables
  localparam logic [10:0] FSW_KHZ [8] = '{11'h13b, 11'h1a9, 11'h226, 11'h28a,
                                         11'h339, 11'h384, 11'h401, 11'h4c9};
  localparam logic [2:0] RAMP_SCALE_HALF [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
  localparam logic [3:0] OFFSET_STEP_MV = 4'h2;
  localparam logic [13:0] BLT_MV [5] = '{14'h27d8, 14'h0af0, 14'h109a, 14'h1770, 14'h1fa4};
  localparam logic [2:0] BLT_HIGH_IDX = 3'h0;
  localparam logic [2:0] BLT_IDX_STEP = 3'h1;
  localparam logic [10:0] TGT_BASE_MV = 11'h1f4;
  localparam logic [10:0] TGT_STEP_MV = 11'h032;

  // Synchronised pin vector layout
  localparam int SYNC_W = 4;
  localparam int SY_RRS_LSB = 0;
  localparam int SY_RIE = 2;
  localparam int SY_TRK = 3;

  typedef enum logic {PH_STRAP_LOAD, PH_RUN} ccr_phase_t;

  typedef struct packed {
    logic [2:0] ramp_scale_half;
    logic [10:0] freq_khz;
    logic [3:0] offset_mv;
    logic [13:0] lockout_mv;
    logic [10:0] target_mv;
  } ccr_dec_t;

endpackage

/* File: pkg/ccr_sync_if.sv */
`timescale 1ns/10ps
interface ccr_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport owner (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

/* File: hdl/ccr_sync.sv */
`timescale 1ns/10ps
module ccr_sync
  import ccr_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  input wire logic ce_i,
  // Pin levels in, synchronised levels out
  ccr_sync_if.sync sif
);

  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] meta_d;
  logic [SYNC_W-1:0] stable_q;
  logic [SYNC_W-1:0] stable_d;

  // No reset: the pins keep flowing through while reset is held, so straps are settled
  always_comb
  begin
    meta_d = meta_q;
    stable_d = stable_q;
    if (ce_i)
    begin
      meta_d = sif.raw;
      stable_d = meta_q;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    meta_q <= meta_d;
    stable_q <= stable_d;
  end

  assign sif.synced = stable_q;

endmodule

/* File: hdl/ccr_config_regs.sv */
`timescale 1ns/10ps
module ccr_config_regs
  import ccr_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Command port from the bus engine
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_wdata_i,
  output logic [7:0] cmd_rdata_o,
  output logic cmd_ack_o,
  output logic cmd_miss_o,
  // Strap pins
  input wire logic strap_ramp_injection_enable_i,
  input wire logic [1:0] strap_ramp_resistor_select_i,
  // Nonvolatile spare storage
  input wire logic nv_spare_i,
  output logic nv_wr_o,
  output logic nv_wdata_o,
  // Tracking gate
  input wire logic tracking_input_valid_i,
  input wire logic switch_request_i,
  output logic switching_enable_o,
  // Loop configuration
  output logic ramp_injection_enable_o,
  output logic [1:0] ramp_resistor_select_o,
  output logic [2:0] ramp_scale_half_o,
  output logic [2:0] switching_freq_select_o,
  output logic [10:0] switching_freq_khz_o,
  output logic offset_scheme_select_o,
  output logic [1:0] manual_offset_trim_o,
  output logic [3:0] offset_correction_mv_o,
  output logic [2:0] bias_lockout_threshold_o,
  output logic [13:0] bias_lockout_mv_o,
  output logic power_good_window_select_o,
  output logic auxiliary_nv_output_o,
  output logic tracking_gate_bypass_o,
  output logic [3:0] tracking_target_select_o,
  output logic [10:0] tracking_target_mv_o
);

  ccr_sync_if #(.W(SYNC_W)) sif ();

  ccr_sync ccr_sync_inst (
    .mclk_i(mclk_i),
    .ce_i(ce_i),
    .sif(sif)
  );

  assign sif.raw = {tracking_input_valid_i, strap_ramp_injection_enable_i,
                    strap_ramp_resistor_select_i};

  logic trk_ok;
  assign trk_ok = sif.synced[SY_TRK];

  function automatic logic [IDX_W:0] cmd_decode(input logic [7:0] code);
    logic [IDX_W:0] res;
    res = '0;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (code == REG_ADDR[i])
      begin
        res = {1'b1, IDX_W'(i)};
      end
    end
    return res;
  endfunction

  // Used both for the live path and for the reset constant, so the two cannot drift
  function automatic ccr_dec_t ccr_decode(input logic [7:0] lf, input logic [7:0] of,
                                          input logic [7:0] bl, input logic [7:0] pt);
    ccr_dec_t d;
    logic [TRIM_W-1:0] trim_eff;
    logic [2:0] blt_idx;
    d = '0;
    trim_eff = of[OSS_BIT] ? '0 : of[TRIM_LSB +: TRIM_W];
    if (bl[BLT_LSB + BLT_RANGE_BIT])
    begin
      blt_idx = 3'({1'b0, bl[BLT_LSB +: BLT_RANGE_BIT]}) + BLT_IDX_STEP;
    end
    else
    begin
      blt_idx = BLT_HIGH_IDX;
    end
    d.ramp_scale_half = RAMP_SCALE_HALF[lf[RRS_LSB +: RRS_W]];
    d.freq_khz = FSW_KHZ[lf[FSW_LSB +: FSW_W]];
    d.offset_mv = 4'(trim_eff * OFFSET_STEP_MV);
    d.lockout_mv = BLT_MV[blt_idx];
    d.target_mv = 11'(TGT_BASE_MV + 11'(pt[TGT_LSB +: TGT_W]) * TGT_STEP_MV);
    return d;
  endfunction

  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] regs_d [NUM_REGS];
  ccr_phase_t phase_q;
  ccr_phase_t phase_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic ack_q;
  logic ack_d;
  logic miss_q;
  logic miss_d;
  logic nv_wr_q;
  logic nv_wr_d;
  logic sw_en_q;
  logic sw_en_d;
  ccr_dec_t dec_q;
  ccr_dec_t dec_d;
  logic [IDX_W:0] hit_idx;
  logic hit;
  logic [IDX_W-1:0] idx;

  assign hit_idx = cmd_decode(cmd_code_i);
  assign hit = hit_idx[IDX_W];
  assign idx = hit_idx[IDX_W-1:0];

  always_comb
  begin
    regs_d = regs_q;
    phase_d = phase_q;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    miss_d = 1'b0;
    nv_wr_d = 1'b0;
    if (ce_i)
    begin
      // First enabled cycle after every reset: take straps and the stored spare
      if (phase_q == PH_STRAP_LOAD)
      begin
        regs_d[IDX_LOOP_FREQ][RIE_BIT] = sif.synced[SY_RIE];
        regs_d[IDX_LOOP_FREQ][RRS_LSB +: RRS_W] = sif.synced[SY_RRS_LSB +: RRS_W];
        regs_d[IDX_PG_TRK][SPARE_BIT] = nv_spare_i;
        phase_d = PH_RUN;
      end
      // A write in the load cycle lands after the strap and so wins
      if (cmd_wr_i && hit)
      begin
        regs_d[idx] = cmd_wdata_i & REG_MASK[idx];
        nv_wr_d = (idx == IDX_W'(IDX_PG_TRK));
      end
      if (cmd_wr_i || cmd_rd_i)
      begin
        ack_d = 1'b1;
        miss_d = !hit;
      end
      if (cmd_rd_i)
      begin
        rdata_d = hit ? regs_q[idx] : '0;
      end
    end
  end

  always_comb
  begin
    dec_d = dec_q;
    sw_en_d = sw_en_q;
    if (ce_i)
    begin
      dec_d = ccr_decode(regs_d[IDX_LOOP_FREQ], regs_d[IDX_OFFSET], regs_d[IDX_BIAS],
                         regs_d[IDX_PG_TRK]);
      sw_en_d = switch_request_i && (regs_d[IDX_PG_TRK][BYP_BIT] || trk_ok);
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs_q[i] <= REG_RST[i];
      end
      phase_q <= PH_STRAP_LOAD;
      rdata_q <= '0;
      ack_q <= 1'b0;
      miss_q <= 1'b0;
      nv_wr_q <= 1'b0;
      sw_en_q <= 1'b0;
      dec_q <= ccr_decode(RST_LOOP_FREQ, RST_OFFSET, RST_BIAS, RST_PG_TRK);
    end
    else
    begin
      regs_q <= regs_d;
      phase_q <= phase_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      miss_q <= miss_d;
      nv_wr_q <= nv_wr_d;
      sw_en_q <= sw_en_d;
      dec_q <= dec_d;
    end
  end

  assign cmd_rdata_o = rdata_q;
  assign cmd_ack_o = ack_q;
  assign cmd_miss_o = miss_q;
  assign nv_wr_o = nv_wr_q;
  assign nv_wdata_o = regs_q[IDX_PG_TRK][SPARE_BIT];
  assign switching_enable_o = sw_en_q;
  assign ramp_injection_enable_o = regs_q[IDX_LOOP_FREQ][RIE_BIT];
  assign ramp_resistor_select_o = regs_q[IDX_LOOP_FREQ][RRS_LSB +: RRS_W];
  assign ramp_scale_half_o = dec_q.ramp_scale_half;
  assign switching_freq_select_o = regs_q[IDX_LOOP_FREQ][FSW_LSB +: FSW_W];
  assign switching_freq_khz_o = dec_q.freq_khz;
  assign offset_scheme_select_o = regs_q[IDX_OFFSET][OSS_BIT];
  assign manual_offset_trim_o = regs_q[IDX_OFFSET][TRIM_LSB +: TRIM_W];
  assign offset_correction_mv_o = dec_q.offset_mv;
  assign bias_lockout_threshold_o = regs_q[IDX_BIAS][BLT_LSB +: BLT_W];
  assign bias_lockout_mv_o = dec_q.lockout_mv;
  assign power_good_window_select_o = regs_q[IDX_PG_TRK][PGW_BIT];
  assign auxiliary_nv_output_o = regs_q[IDX_PG_TRK][SPARE_BIT];
  assign tracking_gate_bypass_o = regs_q[IDX_PG_TRK][BYP_BIT];
  assign tracking_target_select_o = regs_q[IDX_PG_TRK][TGT_LSB +: TGT_W];
  assign tracking_target_mv_o = dec_q.target_mv;

  // Back-to-back spare writes are legal, so the pulse may legitimately continue
  logic pt_wr;
  assign pt_wr = ce_i && cmd_wr_i && (cmd_code_i == ADDR_PG_TRK);

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  strap_ramp_a: assert property (
    phase_q == PH_STRAP_LOAD && ce_i && !cmd_wr_i
    |=> ramp_injection_enable_o == $past(sif.synced[SY_RIE]))
    else $error("ramp injection enable did not load its strap");

  strap_reload_a: assert property (
    $past(sys_rst_i) && ce_i && !cmd_wr_i
    |=> ramp_resistor_select_o == $past(sif.synced[SY_RRS_LSB +: RRS_W]))
    else $error("resistor select not reloaded after reset");

  host_write_a: assert property (
    ce_i && cmd_wr_i && cmd_code_i == ADDR_LOOP_FREQ
    |=> ramp_injection_enable_o == $past(cmd_wdata_i[RIE_BIT])
        && ramp_resistor_select_o == $past(cmd_wdata_i[RRS_LSB +: RRS_W])
        && switching_freq_select_o == $past(cmd_wdata_i[FSW_LSB +: FSW_W]))
    else $error("host write did not replace loop fields");

  ramp_scale_a: assert property (
    ramp_scale_half_o == RAMP_SCALE_HALF[ramp_resistor_select_o])
    else $error("ramp scale does not match resistor select");

  freq_reset_a: assert property (
    $past(sys_rst_i) |-> switching_freq_select_o == FSW_RST
    && switching_freq_khz_o == FSW_KHZ[FSW_RST])
    else $error("frequency code not at reset value");

  offset_reset_a: assert property (
    $past(sys_rst_i) |-> offset_scheme_select_o && manual_offset_trim_o == '0)
    else $error("offset scheme not automatic after reset");

  manual_gate_a: assert property (
    offset_scheme_select_o |-> offset_correction_mv_o == '0)
    else $error("manual trim leaked into automatic scheme");

  trim_step_a: assert property (
    !offset_scheme_select_o
    |-> offset_correction_mv_o == 4'(manual_offset_trim_o * OFFSET_STEP_MV))
    else $error("offset correction step wrong");

  lockout_high_a: assert property (
    !bias_lockout_threshold_o[BLT_RANGE_BIT] |-> bias_lockout_mv_o == BLT_MV[BLT_HIGH_IDX])
    else $error("lockout threshold not at high setting");

  pg_reset_a: assert property (
    $past(sys_rst_i) |-> power_good_window_select_o && !tracking_gate_bypass_o)
    else $error("power-good window not wide after reset");

  spare_nv_a: assert property (
    pt_wr
    |=> nv_wr_o && auxiliary_nv_output_o == $past(cmd_wdata_i[SPARE_BIT])
        ##1 (nv_wr_o == $past(pt_wr)))
    else $error("spare write not stored or not pulsed");

  track_gate_a: assert property (
    switching_enable_o && !tracking_gate_bypass_o && $past(ce_i) |-> $past(trk_ok))
    else $error("switching enabled without valid tracking input");

  target_reset_a: assert property (
    $past(sys_rst_i) |-> tracking_target_select_o == TGT_RST)
    else $error("tracking target not at reset value");

  reserved_zero_a: assert property (
    cmd_ack_o && !cmd_miss_o && $past(cmd_rd_i) && $past(cmd_code_i) == ADDR_OFFSET
    |-> (cmd_rdata_o & ~MASK_OFFSET) == '0)
    else $error("reserved bits read as nonzero");

  loop_write_c: cover property (ce_i && cmd_wr_i && cmd_code_i == ADDR_LOOP_FREQ);
  miss_read_c: cover property (cmd_ack_o && cmd_miss_o);
  gated_start_c: cover property (!tracking_gate_bypass_o && switching_enable_o);
  manual_trim_c: cover property (!offset_scheme_select_o && offset_correction_mv_o != '0);

endmodule

/* File: test/ccr_host_model.sv */
`timescale 1ns/10ps
module ccr_host_model
(
  // Clock
  input wire logic mclk_i,
  // Command port towards the register bank
  output logic [7:0] cmd_code_i,
  output logic cmd_wr_i,
  output logic cmd_rd_i,
  output logic [7:0] cmd_wdata_i,
  input wire logic [7:0] cmd_rdata_o,
  input wire logic cmd_ack_o,
  input wire logic cmd_miss_o
);
  initial
  begin
    cmd_code_i = 8'h00;
    cmd_wr_i = 1'b0;
    cmd_rd_i = 1'b0;
    cmd_wdata_i = 8'h00;
  end

  // One command; strobes move only at the falling edge
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] wd,
                      output logic ok, output logic [7:0] rd, output logic miss);
    ok = 1'b0;
    rd = 8'h00;
    miss = 1'b0;
    @(negedge mclk_i);
    cmd_code_i = code;
    cmd_wdata_i = wr ? wd : ~cmd_wdata_i;
    cmd_wr_i = wr;
    cmd_rd_i = !wr;
    @(negedge mclk_i);
    // Strobes are one-cycle pulses; code and data stand until the answer is seen
    cmd_wr_i = 1'b0;
    cmd_rd_i = 1'b0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      if (cmd_ack_o === 1'b1)
      begin
        ok = 1'b1;
        rd = cmd_rdata_o;
        miss = cmd_miss_o;
      end
      else
      begin
        @(negedge mclk_i);
      end
    end
    // Code and data go stale together at the next falling edge, so nothing may be latched late
    @(negedge mclk_i);
    cmd_code_i = ~code;
    cmd_wdata_i = ~wd;
  endtask
endmodule

/* File: test/tb_ccr_config_regs.sv */
`timescale 1ns/10ps
module tb_ccr_config_regs;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] cmd_code_i, cmd_wdata_i, cmd_rdata_o;
  logic cmd_wr_i, cmd_rd_i, cmd_ack_o, cmd_miss_o;
  logic strap_ramp_injection_enable_i = 1'b1;
  logic [1:0] strap_ramp_resistor_select_i = 2'h2;
  logic nv_spare_i = 1'b1;
  logic nv_wr_o, nv_wdata_o;
  logic tracking_input_valid_i = 1'b0;
  logic switch_request_i = 1'b0;
  logic switching_enable_o, ramp_injection_enable_o, offset_scheme_select_o;
  logic power_good_window_select_o, auxiliary_nv_output_o, tracking_gate_bypass_o;
  logic [1:0] ramp_resistor_select_o, manual_offset_trim_o;
  logic [2:0] ramp_scale_half_o, switching_freq_select_o, bias_lockout_threshold_o;
  logic [3:0] offset_correction_mv_o, tracking_target_select_o;
  logic [10:0] switching_freq_khz_o, tracking_target_mv_o;
  logic [13:0] bias_lockout_mv_o;
  int n_mismatch = 0;
  int compares = 0;
  logic [7:0] rd;
  logic miss;
  int nv_pulses = 0;

  always #10 mclk_i = ~mclk_i;

  // The store pulse lasts one cycle, so it is counted where it stands
  always @(negedge mclk_i)
    if (nv_wr_o === 1'b1)
      nv_pulses++;

  ccr_config_regs ccr_config_regs_inst (.*);
  ccr_host_model ccr_host_model_inst (.*);

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] code, input logic [7:0] wd);
    logic ok;
    ccr_host_model_inst.xfer(wr, code, wd, ok, rd, miss);
    if (ok !== 1'b1)
    begin
      chk("ack", ok, 1'b1);
      final_report();
    end
  endtask

  task automatic rdchk(input logic [7:0] code, input logic [7:0] exp);
    bus(1'b0, code, 8'h00);
    chk("rdata", rd, exp);
  endtask

  task automatic t_power_on(input logic rie, input logic [1:0] rrs, input logic nv);
    logic [2:0] sc[4] = '{3'h1, 3'h2, 3'h4, 3'h6};
    strap_ramp_injection_enable_i = rie;
    strap_ramp_resistor_select_i = rrs;
    nv_spare_i = nv;
    sys_rst_i = 1'b1;
    repeat (16) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rdchk(8'hd3, {rie, 1'b0, rrs, 4'h3});
    rdchk(8'hd4, 8'h80);
    rdchk(8'hd6, 8'h00);
    rdchk(8'hd7, {1'b1, nv, 6'h0f});
    chk("rie", ramp_injection_enable_o, rie);
    chk("scale", ramp_scale_half_o, sc[rrs]);
    chk("khz", switching_freq_khz_o, 16'h028a);
    chk("off_mv", offset_correction_mv_o, 16'h0000);
    chk("uvlo_mv", bias_lockout_mv_o, 16'h27d8);
    chk("pg_win", power_good_window_select_o, 1'b1);
    chk("aux", auxiliary_nv_output_o, nv);
    chk("trk_mv", tracking_target_mv_o, 16'h04e2);
  endtask

  task automatic t_reserved();
    logic [7:0] code[4] = '{8'hd3, 8'hd4, 8'hd6, 8'hd7};
    logic [7:0] msk[4] = '{8'hb7, 8'he0, 8'h07, 8'hdf};
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, code[i], 8'hff);
      rdchk(code[i], msk[i]);
    end
    chk("rrs", ramp_resistor_select_o, 2'h3);
  endtask

  task automatic t_freq_ramp();
    logic [10:0] khz[8] = '{11'h13b, 11'h1a9, 11'h226, 11'h28a,
                            11'h339, 11'h384, 11'h401, 11'h4c9};
    logic [2:0] sc[4] = '{3'h1, 3'h2, 3'h4, 3'h6};
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, 8'hd3, {c[0], 1'b0, c[1:0], 1'b0, c[2:0]});
      chk("khz", switching_freq_khz_o, khz[c]);
      chk("fsw", switching_freq_select_o, c[2:0]);
      chk("scale", ramp_scale_half_o, sc[c[1:0]]);
      chk("rie", ramp_injection_enable_o, c[0]);
    end
  endtask

  task automatic t_offset();
    for (int s = 0; s < 2; s++)
      for (int t = 0; t < 4; t++)
      begin
        bus(1'b1, 8'hd4, {s[0], t[1:0], 5'h1f});
        chk("scheme", offset_scheme_select_o, s[0]);
        chk("trim", manual_offset_trim_o, t[1:0]);
        chk("off_mv", offset_correction_mv_o, s ? 0 : 2 * t);
      end
  endtask

  task automatic t_bias();
    logic [13:0] mv[4] = '{14'h0af0, 14'h109a, 14'h1770, 14'h1fa4};
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, 8'hd6, {5'h1f, c[2:0]});
      chk("uvlo", bias_lockout_threshold_o, c[2:0]);
      chk("uvlo_mv", bias_lockout_mv_o, c < 4 ? 14'h27d8 : mv[c - 4]);
    end
  endtask

  task automatic t_track();
    int n0;
    for (int t = 0; t < 16; t++)
    begin
      bus(1'b1, 8'hd7, {t[0], 3'h0, t[3:0]});
      chk("pg_win", power_good_window_select_o, t[0]);
      chk("trk_sel", tracking_target_select_o, t[3:0]);
      chk("trk_mv", tracking_target_mv_o, 500 + 50 * t);
    end
    chk("bypass", tracking_gate_bypass_o, 1'b0);
    switch_request_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk("sw_en", switching_enable_o, 1'b0);
    tracking_input_valid_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk("sw_en", switching_enable_o, 1'b1);
    tracking_input_valid_i = 1'b0;
    n0 = nv_pulses;
    bus(1'b1, 8'hd7, 8'hdf);
    chk("nv_wr", 16'(nv_pulses - n0), 16'h0001);
    chk("nv_data", nv_wdata_o, 1'b1);
    chk("aux", auxiliary_nv_output_o, 1'b1);
    chk("bypass", tracking_gate_bypass_o, 1'b1);
    repeat (4) @(negedge mclk_i);
    chk("nv_wr", nv_wr_o, 1'b0);
    chk("nv_cnt", 16'(nv_pulses - n0), 16'h0001);
    chk("sw_en", switching_enable_o, 1'b1);
    switch_request_i = 1'b0;
    @(negedge mclk_i);
    chk("sw_en", switching_enable_o, 1'b0);
  endtask

  task automatic t_unmapped();
    logic ok;
    bus(1'b1, 8'hd6, 8'h05);
    bus(1'b1, 8'hd5, 8'hff);
    chk("miss", miss, 1'b1);
    bus(1'b0, 8'hd5, 8'h00);
    chk("miss", miss, 1'b1);
    chk("rdata", rd, 8'h00);
    // A frozen bank must neither answer nor take the write
    ce_i = 1'b0;
    ccr_host_model_inst.xfer(1'b1, 8'hd6, 8'h02, ok, rd, miss);
    chk("ack", ok, 1'b0);
    ce_i = 1'b1;
    rdchk(8'hd6, 8'h05);
    chk("miss", miss, 1'b0);
  endtask

  initial
  begin
    t_power_on(1'b1, 2'h2, 1'b1);
    t_reserved();
    t_freq_ramp();
    t_offset();
    t_bias();
    t_track();
    t_unmapped();
    t_power_on(1'b0, 2'h1, 1'b0);
    final_report();
  end
endmodule
